// >>> hw/frc_consts.vh
// Constants for the free-format serial receive command block.
// Included by the block's design files; definitions only.
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH

// Per-slot registers: slot 0 at 0x00, slot 1 at 0x20, offset in haddr[4:0]
`define FRC_OFF_CHAN 5'h00
`define FRC_OFF_RESULT 5'h04
`define FRC_OFF_COUNT 5'h08
`define FRC_OFF_LIMIT 5'h0c
`define FRC_OFF_DEST 5'h10
`define FRC_OFF_CTRL 5'h14

// Global registers
`define FRC_ADDR_CMD 8'h40
`define FRC_ADDR_OTHER 8'h44
`define FRC_ADDR_STAT 8'h48

// Slot control word bits
`define FRC_CTRL_GO 0
`define FRC_CTRL_ACTIVE 0
`define FRC_CTRL_DONE 1
`define FRC_CTRL_ABN 2

// Command word fields
`define FRC_CMD_OP_LSB 0
`define FRC_CMD_OP_MSB 2
`define FRC_CMD_CH_LSB 4
`define FRC_CMD_CH_MSB 5
`define FRC_CMD_UNIT 8
`define FRC_OP_CFG 3'h1
`define FRC_OP_REINIT 3'h2
`define FRC_OP_PROTO 3'h3

// Channel selector values
`define FRC_CHAN_ONE 16'h0001
`define FRC_CHAN_TWO 16'h0002

// Result codes
`define FRC_RES_OK 16'h0000
`define FRC_ERR_SIMUL 16'h7ff0
`define FRC_ERR_PROTO 16'h7ff2
`define FRC_ERR_CHAN 16'h7f01

// Receive buffer: 16 units per channel
`define FRC_BUF_AW 4
`define FRC_DW 16

// Reset values and re-initialisation length
`define FRC_UNIT_RESET 2'b00
`define FRC_REINIT_CYCLES 5'h10

`endif

// >>> hw/frc_mem.v
// Receive buffer memory shared by both channels, channel in the top address bit.
// One write port, one read port; read data is registered one cycle after address.
`timescale 1ns/100ps
`include "frc_consts.vh"

module frc_mem (
  input wire i_clk,
  input wire i_we,
  input wire [`FRC_BUF_AW:0] i_waddr,
  input wire [`FRC_DW-1:0] i_wdata,
  input wire [`FRC_BUF_AW:0] i_raddr,
  output reg [`FRC_DW-1:0] o_rdata
);

  reg [`FRC_DW-1:0] mem [0:(2<<`FRC_BUF_AW)-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

// >>> hw/frc_top.v
// Free-format serial receive command block with an AHB-Lite register slave.
// Assumes a single clock, synchronous inputs, one scan-end pulse per host scan,
// and a destination memory that accepts one write per cycle without stalling.
//
// Overview of operation
// [R1] - Host addresses module by its base select
// [R2] - Channel selector word: 1 or 2 only
// [R3] - Result word: zero ok, else error code
// [R4] - Count word holds units delivered, zero or more
// [R5] - Host sets limit of at least one
// [R6] - Counts in bytes or words per channel
// [R7] - Host issues receive only on read request
// [R8] - Copy buffered data to consecutive destination words
// [R9] - Excess data discarded, still normal completion
// [R10] - Truncated receive reports limit as count
// [R11] - Second receive on busy channel ignored
// [R12] - Busy restrictions apply per channel only
// [R13] - Config change during receive fails 7FF0
// [R14] - Config change before receive runs concurrently
// [R15] - Host avoids interrupt receive alongside receive
// [R16] - Later of receive and reinit fails 7FF0
// [R17] - Other-protocol command during receive fails 7FF2
// [R18] - Completion flag set and cleared at scan end
// [R19] - Abnormal flag stays low on success
// [R20] - Abnormal flag pulses with completion on failure
// [R21] - Failure sets abnormal flag and error result
// [R22] - Host waits for completion flag low
// [R23] - Data buffered per channel until read out
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "frc_consts.vh"

module frc_top (
  input wire i_clk,
  input wire i_rst,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire o_hreadyout,
  output wire o_hresp,
  output reg [31:0] o_hrdata,
  input wire [1:0] i_rx_valid,
  input wire [15:0] i_rx_data_ch1,
  input wire [15:0] i_rx_data_ch2,
  output wire [1:0] o_rx_ready,
  input wire i_scan_end,
  output wire [1:0] o_read_request,
  output reg o_dst_we,
  output reg [15:0] o_dst_addr,
  output wire [15:0] o_dst_data,
  output reg [1:0] o_completion_flag,
  output reg [1:0] o_abnormal_flag
);

  localparam ST_IDLE = 3'b001;
  localparam ST_COPY = 3'b010;
  localparam ST_DROP = 3'b100;

  function ch_ok;
    input [15:0] v;
    begin
      ch_ok = (v == `FRC_CHAN_ONE) || (v == `FRC_CHAN_TWO);
    end
  endfunction

  function [4:0] fill;
    input [4:0] wr;
    input [4:0] rd;
    begin
      fill = wr - rd;
    end
  endfunction

  function [4:0] clip;
    input [4:0] avail;
    input [15:0] lim;
    begin
      if (lim < {11'h000, avail}) begin
        clip = lim[4:0];
      end else begin
        clip = avail;
      end
    end
  endfunction

  // Per-slot command state
  reg [15:0] chan_sel [0:1];
  reg [15:0] result [0:1];
  reg [15:0] count [0:1];
  reg [15:0] limit [0:1];
  reg [15:0] dest [0:1];
  reg [1:0] active;
  reg [1:0] queued;
  reg [1:0] done_pend;
  reg [1:0] abn_pend;

  // Per-channel buffer state
  reg [4:0] wr_ptr [0:1];
  reg [4:0] rd_ptr [0:1];
  reg [1:0] unit_words;

  reg [15:0] other_result;
  reg reinit_active;
  reg [4:0] reinit_cnt;

  // Copy engine
  reg [2:0] state;
  reg eng_slot;
  reg eng_ch;
  reg [4:0] eng_avail;
  reg [4:0] eng_n;
  reg [4:0] eng_idx;
  reg [15:0] eng_dest;

  // Bus data phase
  reg d_wr;
  reg [7:0] d_addr;
  reg [31:0] rd_val;
  reg rs;

  wire a_take = i_hsel & i_hready & i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  wire [4:0] fill0 = fill(wr_ptr[0], rd_ptr[0]);
  wire [4:0] fill1 = fill(wr_ptr[1], rd_ptr[1]);
  assign o_read_request = {fill1 != 5'h00, fill0 != 5'h00}; // [R7] [R23]
  // Channel 1 wins a shared write cycle; channel 2 is stalled, never dropped
  wire wr_a = i_rx_valid[0] & ~fill0[4] & ~reinit_active;
  wire wr_b = i_rx_valid[1] & ~fill1[4] & ~reinit_active & ~wr_a;
  assign o_rx_ready = {~fill1[4] & ~reinit_active & ~wr_a, ~fill0[4] & ~reinit_active}; // [R23]
  wire [15:0] rx_raw = wr_a ? i_rx_data_ch1 : i_rx_data_ch2;
  wire wr_unit = wr_a ? unit_words[0] : unit_words[1];
  wire [15:0] rx_wdata = wr_unit ? rx_raw : {8'h00, rx_raw[7:0]}; // [R6]
  wire [4:0] wr_sel_ptr = wr_a ? wr_ptr[0] : wr_ptr[1];
  wire [4:0] mem_waddr = {wr_b, wr_sel_ptr[3:0]};
  wire [4:0] rd_base = rd_ptr[eng_ch];
  wire [3:0] rd_off = rd_base[3:0] + eng_idx[3:0];
  wire [4:0] mem_raddr = {eng_ch, rd_off}; // [R8]
  // Channel index of an active slot is bit 1 of its selector (1 -> 0, 2 -> 1)
  wire [1:0] rx_busy;
  assign rx_busy[0] = (active[0] & ~chan_sel[0][1]) | (active[1] & ~chan_sel[1][1]);
  assign rx_busy[1] = (active[0] & chan_sel[0][1]) | (active[1] & chan_sel[1][1]);
  wire pick_slot = ~queued[0];
  wire pick_ch = chan_sel[pick_slot][1];
  wire [4:0] pick_avail = pick_ch ? fill1 : fill0;
  wire slot_wr = d_wr & (d_addr[7:6] == 2'b00);
  wire ws = d_addr[5];
  wire [4:0] woff = d_addr[4:0];
  wire go = slot_wr & (woff == `FRC_OFF_CTRL) & i_hwdata[`FRC_CTRL_GO];
  wire cmd = d_wr & (d_addr == `FRC_ADDR_CMD);
  wire [2:0] cmd_op = i_hwdata[`FRC_CMD_OP_MSB:`FRC_CMD_OP_LSB];
  wire [15:0] cmd_ch = {14'h0000, i_hwdata[`FRC_CMD_CH_MSB:`FRC_CMD_CH_LSB]};
  wire cmd_idx = cmd_ch[1];

  frc_mem u_mem (
    .i_clk(i_clk),
    .i_we(wr_a | wr_b),
    .i_waddr(mem_waddr),
    .i_wdata(rx_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(o_dst_data)
  );

  always @* begin
    rd_val = 32'h00000000;
    rs = i_haddr[5];
    if (i_haddr[31:8] != 24'h000000) begin
      rd_val = 32'h00000000;
    end else if (i_haddr[7:6] == 2'b00) begin
      if (i_haddr[4:0] == `FRC_OFF_CHAN) begin
        rd_val = {16'h0000, chan_sel[rs]};
      end else if (i_haddr[4:0] == `FRC_OFF_RESULT) begin
        rd_val = {16'h0000, result[rs]};
      end else if (i_haddr[4:0] == `FRC_OFF_COUNT) begin
        rd_val = {16'h0000, count[rs]};
      end else if (i_haddr[4:0] == `FRC_OFF_LIMIT) begin
        rd_val = {16'h0000, limit[rs]};
      end else if (i_haddr[4:0] == `FRC_OFF_DEST) begin
        rd_val = {16'h0000, dest[rs]};
      end else if (i_haddr[4:0] == `FRC_OFF_CTRL) begin
        rd_val = {29'h00000000, o_abnormal_flag[rs], o_completion_flag[rs], active[rs]};
      end
    end else if (i_haddr[7:0] == `FRC_ADDR_OTHER) begin
      rd_val = {16'h0000, other_result};
    end else if (i_haddr[7:0] == `FRC_ADDR_STAT) begin
      rd_val = {27'h0000000, reinit_active, unit_words, o_read_request};
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      d_wr <= 1'b0;
      d_addr <= 8'h00;
      o_hrdata <= 32'h00000000;
    end else begin
      d_wr <= a_take & i_hwrite;
      d_addr <= i_haddr[7:0];
      if (a_take & ~i_hwrite) begin
        o_hrdata <= rd_val;
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      chan_sel[0] <= 16'h0000;
      chan_sel[1] <= 16'h0000;
      result[0] <= `FRC_RES_OK;
      result[1] <= `FRC_RES_OK;
      count[0] <= 16'h0000;
      count[1] <= 16'h0000;
      limit[0] <= 16'h0000;
      limit[1] <= 16'h0000;
      dest[0] <= 16'h0000;
      dest[1] <= 16'h0000;
      active <= 2'b00;
      queued <= 2'b00;
      done_pend <= 2'b00;
      abn_pend <= 2'b00;
      o_completion_flag <= 2'b00;
      o_abnormal_flag <= 2'b00;
      wr_ptr[0] <= 5'h00;
      wr_ptr[1] <= 5'h00;
      rd_ptr[0] <= 5'h00;
      rd_ptr[1] <= 5'h00;
      unit_words <= `FRC_UNIT_RESET;
      other_result <= `FRC_RES_OK;
      reinit_active <= 1'b0;
      reinit_cnt <= 5'h00;
      state <= ST_IDLE;
      eng_slot <= 1'b0;
      eng_ch <= 1'b0;
      eng_avail <= 5'h00;
      eng_n <= 5'h00;
      eng_idx <= 5'h00;
      eng_dest <= 16'h0000;
      o_dst_we <= 1'b0;
      o_dst_addr <= 16'h0000;
    end else begin
      o_dst_we <= 1'b0;

      // Flags follow the pending bits at each scan end; a completion in the
      // same cycle lands below and survives into the next scan
      if (i_scan_end) begin
        o_completion_flag <= done_pend; // [R18]
        o_abnormal_flag <= abn_pend; // [R19] [R20]
        done_pend <= 2'b00;
        abn_pend <= 2'b00;
      end
      if (wr_a) begin
        wr_ptr[0] <= wr_ptr[0] + 5'h01; // [R23]
      end
      if (wr_b) begin
        wr_ptr[1] <= wr_ptr[1] + 5'h01; // [R23]
      end
      // Parameters of an active slot are frozen so its channel stays known
      if (slot_wr & ~active[ws]) begin
        if (woff == `FRC_OFF_CHAN) begin
          chan_sel[ws] <= i_hwdata[15:0];
        end else if (woff == `FRC_OFF_LIMIT) begin
          limit[ws] <= i_hwdata[15:0];
        end else if (woff == `FRC_OFF_DEST) begin
          dest[ws] <= i_hwdata[15:0];
        end
      end

      if (go & ~active[ws]) begin
        if (!ch_ok(chan_sel[ws])) begin
          result[ws] <= `FRC_ERR_CHAN; // [R21]
          count[ws] <= 16'h0000;
          done_pend[ws] <= 1'b1;
          abn_pend[ws] <= 1'b1;
        end else if (active[~ws] && chan_sel[~ws] == chan_sel[ws]) begin
          result[ws] <= result[ws]; // [R11] [R12]
        end else if (reinit_active) begin
          result[ws] <= `FRC_ERR_SIMUL; // [R16] [R21]
          count[ws] <= 16'h0000;
          done_pend[ws] <= 1'b1;
          abn_pend[ws] <= 1'b1;
        end else begin
          active[ws] <= 1'b1; // [R12]
          queued[ws] <= 1'b1;
        end
      end

      if (cmd) begin
        if (cmd_op == `FRC_OP_CFG) begin
          if (!ch_ok(cmd_ch)) begin
            other_result <= `FRC_ERR_CHAN;
          end else if (rx_busy[cmd_idx]) begin
            other_result <= `FRC_ERR_SIMUL; // [R13]
          end else begin
            unit_words[cmd_idx] <= i_hwdata[`FRC_CMD_UNIT]; // [R6] [R14]
            other_result <= `FRC_RES_OK;
          end
        end else if (cmd_op == `FRC_OP_REINIT) begin
          if ((|active) | reinit_active) begin
            other_result <= `FRC_ERR_SIMUL; // [R16]
          end else begin
            reinit_active <= 1'b1;
            reinit_cnt <= `FRC_REINIT_CYCLES;
            other_result <= `FRC_RES_OK;
          end
        end else if (cmd_op == `FRC_OP_PROTO) begin
          if (ch_ok(cmd_ch) && rx_busy[cmd_idx]) begin
            other_result <= `FRC_ERR_PROTO; // [R17]
          end else begin
            other_result <= `FRC_RES_OK;
          end
        end
      end

      // Re-initialisation flushes both buffers and restores unit modes
      if (reinit_active) begin
        reinit_cnt <= reinit_cnt - 5'h01;
        if (reinit_cnt == 5'h01) begin
          reinit_active <= 1'b0;
          wr_ptr[0] <= 5'h00;
          wr_ptr[1] <= 5'h00;
          rd_ptr[0] <= 5'h00;
          rd_ptr[1] <= 5'h00;
          unit_words <= `FRC_UNIT_RESET;
        end
      end

      case (state)
        ST_IDLE: begin
          if (|queued) begin
            eng_slot <= pick_slot;
            eng_ch <= pick_ch;
            eng_avail <= pick_avail;
            eng_n <= clip(pick_avail, limit[pick_slot]); // [R9]
            eng_idx <= 5'h00;
            eng_dest <= dest[pick_slot];
            queued[pick_slot] <= 1'b0;
            state <= ST_COPY;
          end
        end
        ST_COPY: begin
          if (eng_idx == eng_n) begin
            state <= ST_DROP;
          end else begin
            o_dst_we <= 1'b1; // [R8]
            o_dst_addr <= eng_dest + {11'h000, eng_idx}; // [R8]
            eng_idx <= eng_idx + 5'h01;
          end
        end
        ST_DROP: begin
          // Units beyond the limit are released unread
          rd_ptr[eng_ch] <= rd_ptr[eng_ch] + eng_avail; // [R9] [R23]
          result[eng_slot] <= `FRC_RES_OK; // [R3] [R9]
          count[eng_slot] <= {11'h000, eng_n}; // [R4] [R10]
          done_pend[eng_slot] <= 1'b1; // [R18]
          active[eng_slot] <= 1'b0; // [R11]
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> verification/frc_monitor.sv
// Checker for flag timing and delivery order of the receive block.
// Bound into frc_top; sees only its ports.
`timescale 1ns/100ps
module frc_monitor (
  input wire i_clk,
  input wire i_rst,
  input wire i_scan_end,
  input wire [1:0] i_rx_valid,
  input wire [1:0] o_rx_ready,
  input wire [1:0] o_read_request,
  input wire o_dst_we,
  input wire [15:0] o_dst_addr,
  input wire [1:0] o_completion_flag,
  input wire [1:0] o_abnormal_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  done_scan_edge_a: assert property ($changed(o_completion_flag) |-> $past(i_scan_end))
    else $error("completion flag moved off a scan end");
  abn_scan_edge_a: assert property (!$past(i_scan_end) |-> $stable(o_abnormal_flag))
    else $error("abnormal flag moved off a scan end");
  done_one_scan_a: assert property (o_completion_flag[0] && i_scan_end |=> !o_completion_flag[0])
    else $error("completion flag held past one scan");
  abn_one_scan_a: assert property (o_abnormal_flag[1] && i_scan_end |=> !o_abnormal_flag[1])
    else $error("abnormal flag held past one scan");
  abn_with_done_a: assert property ((o_abnormal_flag & ~o_completion_flag) == 2'b00)
    else $error("abnormal flag without completion flag");
  dst_in_order_a: assert property (o_dst_we && $past(o_dst_we) |-> o_dst_addr == $past(o_dst_addr) + 16'h1)
    else $error("destination address not consecutive");
  burst_bound_a: assert property ($rose(o_dst_we) |-> ##[1:16] !o_dst_we)
    else $error("delivery burst too long");
  req_on_store_a: assert property ($rose(o_read_request[0]) |-> $past(i_rx_valid[0] && o_rx_ready[0]))
    else $error("read request without a stored unit");
endmodule
bind frc_top frc_monitor i_mon (.i_clk, .i_rst, .i_scan_end, .i_rx_valid, .o_rx_ready, .o_read_request,
  .o_dst_we, .o_dst_addr, .o_completion_flag, .o_abnormal_flag);

// >>> verification/frc_src_model.sv
// Far side: serial sources of both channels and the destination memory.
// Units leave a queue only on an edge with valid and ready both high.
`timescale 1ns/100ps
module frc_src_model (
  input wire i_clk,
  input wire [1:0] i_ready,
  input wire i_we,
  input wire [15:0] i_addr,
  input wire [15:0] i_data,
  output logic [1:0] o_valid = 2'b00,
  output logic [15:0] o_data_ch1 = 16'h0,
  output logic [15:0] o_data_ch2 = 16'h0
);
  logic [15:0] q[2][$];
  logic [15:0] mem[int];
  always @(posedge i_clk) begin
    if (i_we)
      mem[i_addr] = i_data;
    if (o_valid[0] && i_ready[0])
      q[0].delete(0);
    if (o_valid[1] && i_ready[1])
      q[1].delete(0);
    o_valid <= {q[1].size() > 0, q[0].size() > 0};
    // Idle lines toggle so a stale unit never looks fresh
    o_data_ch1 <= (q[0].size() > 0) ? q[0][0] : ~o_data_ch1;
    o_data_ch2 <= (q[1].size() > 0) ? q[1][0] : ~o_data_ch2;
  end
endmodule

// >>> verification/testbench.sv
// Bench: register tasks over AHB-Lite, then receive, truncation, busy
// channel, reinit and bad-channel sequences. Uses the source model.
`timescale 1ns/100ps
`include "frc_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic scan_end = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  wire [31:0] hrdata;
  wire hrdy, hresp, we;
  wire [1:0] vld, rdy, rq, cf, af;
  wire [15:0] d1, d2, da, dd;
  int n_fail = 0;
  int check_count = 0;
  int i;
  always #25 clk = ~clk;
  frc_top i_dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_rx_valid(vld), .i_rx_data_ch1(d1), .i_rx_data_ch2(d2),
    .o_rx_ready(rdy), .i_scan_end(scan_end), .o_read_request(rq), .o_dst_we(we), .o_dst_addr(da),
    .o_dst_data(dd), .o_completion_flag(cf), .o_abnormal_flag(af));
  frc_src_model i_src (.i_clk(clk), .i_ready(rdy), .i_we(we), .i_addr(da), .i_data(dd),
    .o_valid(vld), .o_data_ch1(d1), .o_data_ch2(d2));
  task automatic bus(input w, input [31:0] a, input [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input [31:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input [31:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, q)
  endtask
  task automatic scan;
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rx(input [7:0] s, input [31:0] ch, input [31:0] lim, input [31:0] dst);
    wr(s + `FRC_OFF_CHAN, ch);
    wr(s + `FRC_OFF_LIMIT, lim);
    wr(s + `FRC_OFF_DEST, dst);
    wr(s + `FRC_OFF_CTRL, 32'h1);
  endtask
  task automatic fin(input [7:0] s, input [31:0] res, input [31:0] cnt, input [1:0] c);
    for (int k = 0; k < 40; k++) begin
      bus(1'b0, s + `FRC_OFF_CTRL, 32'h0);
      if (q[0] === 1'b0)
        break;
    end
    `CHK("active", 32'h0, q & 32'h1)
    rdc("result", s + `FRC_OFF_RESULT, res);
    if (res == 32'h0)
      rdc("count", s + `FRC_OFF_COUNT, cnt);
    scan();
    `CHK("done", c, cf)
    `CHK("abnormal", (res != 32'h0) ? c : 2'b00, af)
    scan();
    `CHK("flags", 4'h0, {cf, af})
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("status", `FRC_ADDR_STAT, 32'h0);
    wr(32'h80, 32'h5);
    rdc("unmapped", 32'h80, 32'h0);
    for (i = 0; i < 3; i++)
      i_src.q[0].push_back(16'h3a0 + i);
    repeat (8) @(posedge clk);
    rdc("request", `FRC_ADDR_STAT, 32'h1);
    rx(8'h00, `FRC_CHAN_ONE, 32'h2, 32'h100);
    fin(8'h00, `FRC_RES_OK, 32'h2, 2'b01);
    `CHK("byte unit", 16'h00a1, i_src.mem[16'h101])
    rdc("drained", `FRC_ADDR_STAT, 32'h0);
    wr(`FRC_ADDR_CMD, 32'h121);
    rdc("config", `FRC_ADDR_OTHER, 32'h0);
    for (i = 0; i < 4; i++)
      i_src.q[1].push_back(16'hc350 + i);
    repeat (10) @(posedge clk);
    rdc("units", `FRC_ADDR_STAT, 32'ha);
    rx(8'h20, `FRC_CHAN_TWO, 32'h8, 32'h200);
    fin(8'h20, `FRC_RES_OK, 32'h4, 2'b10);
    `CHK("word unit", 16'hc353, i_src.mem[16'h203])
    // Full buffer keeps slot 0 busy long enough for the clashes below
    for (i = 0; i < 16; i++)
      i_src.q[0].push_back(16'h11 * i);
    wr(8'h20, 32'h1);
    wr(8'h2c, 32'h4);
    repeat (20) @(posedge clk);
    rx(8'h00, `FRC_CHAN_ONE, 32'h10, 32'h300);
    wr(`FRC_ADDR_CMD, 32'h11);
    rdc("config busy", `FRC_ADDR_OTHER, `FRC_ERR_SIMUL);
    wr(`FRC_ADDR_CMD, 32'h13);
    rdc("proto busy", `FRC_ADDR_OTHER, `FRC_ERR_PROTO);
    wr(`FRC_ADDR_CMD, 32'h23);
    rdc("proto other", `FRC_ADDR_OTHER, `FRC_RES_OK);
    wr(8'h34, 32'h1);
    rdc("ignored", 8'h34, 32'h0);
    fin(8'h00, `FRC_RES_OK, 32'h10, 2'b01);
    `CHK("last unit", 16'h00ff, i_src.mem[16'h30f])
    wr(`FRC_ADDR_CMD, 32'h2);
    rdc("reinit", `FRC_ADDR_OTHER, `FRC_RES_OK);
    rx(8'h00, `FRC_CHAN_ONE, 32'h4, 32'h400);
    fin(8'h00, `FRC_ERR_SIMUL, 32'h0, 2'b01);
    rdc("byte again", `FRC_ADDR_STAT, 32'h0);
    wr(8'h20, 32'h3);
    wr(8'h34, 32'h1);
    fin(8'h20, `FRC_ERR_CHAN, 32'h0, 2'b10);
    conclude();
  end
endmodule
